// ### design/cscba_pkg.sv
// constants, states and carriers for the compare-scan / invert / decimal-adjust datapath
// assumes one core clock and a plain register port with single-cycle strobes
package cscba_pkg;

  // ****************************************
  // register port
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_PTR = 8'h0c;
  localparam logic [7:0] REG_CNT = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_CYCLES = 8'h1c;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PFX_LSB = 8;
  localparam int MODE_WIDE_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;

  // ****************************************
  // opcodes and prefixes
  // ****************************************
  localparam logic [7:0] OP_STEP = 8'ha1;
  localparam logic [7:0] OP_SCAN = 8'hb1;
  localparam logic [7:0] OP_INVERT = 8'h2f;
  localparam logic [7:0] OP_DECADJ = 8'h27;
  localparam logic [7:0] PFX_NONE = 8'h00;
  localparam logic [7:0] PFX_SHORT = 8'h52;
  localparam logic [7:0] PFX_LONG = 8'h49;

  // ****************************************
  // widths, reset values, decimal adjust
  // ****************************************
  localparam int WIDE_W = 24;
  localparam int SHORT_W = 16;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [23:0] PTR_RST = 24'h000000;
  localparam logic [23:0] CNT_RST = 24'h000000;
  localparam logic [23:0] ONE_24 = 24'h000001;
  localparam logic [15:0] ONE_16 = 16'h0001;
  localparam logic [1:0] LEAD_NONE = 2'h0;
  localparam logic [1:0] LEAD_ONE = 2'h1;
  localparam logic [31:0] CYC_ONE = 32'h00000001;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  localparam logic [7:0] ADJ_LO = 8'h06;
  localparam logic [7:0] ADJ_HI = 8'h60;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_ADDR = 3'b010,
    ST_WAIT = 3'b011,
    ST_EXEC = 3'b100,
    ST_ONE = 3'b101
  } cscba_state_t;

  // flag byte layout; pad bits read as zero
  typedef struct packed {
    logic sign;
    logic zero;
    logic pad5;
    logic half;
    logic pad3;
    logic pv;
    logic sub;
    logic carry;
  } cscba_flags_t;

  localparam cscba_flags_t FLAGS_RST = 8'h00;

endpackage : cscba_pkg

// ### design/cscba_top.sv
// execution datapath for compare-step, compare-scan, accumulator invert and decimal adjust
// assumes data memory answers a read strobe with the byte in the following cycle
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - step compare: flags only, pointer up, count down
// - compare flags: sign, zero, half-borrow, subtract, carry kept
// - step takes 3 cycles, 4 with prefix
// - scan repeats until equal or count zero
// - parity flag set while decremented count nonzero
// - count 16 bits compatible, 24 bits wide
// - scan takes 1 plus 3 per pass, 2 plus 3 per pass with prefix
// - invert: all bits, one cycle, half and subtract
// - decimal adjust from carry, half, digits, direction
// - valid digits, no flags: adds nothing
// - add without carry: low digit corrections
// - add without carry: high corrections set carry
// - add with carry: carry stays, corrections
// - subtract: half cleared, carry kept, FA/A0/9A
// - adjust sets sign, zero, even parity
module cscba_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_busy,
  output logic o_mem_rd,
  output logic [23:0] o_mem_addr,
  input wire logic [7:0] i_mem_data,
  output logic [7:0] o_acc,
  output logic [7:0] o_flags
);

  // ****************************************
  // state
  // ****************************************
  cscba_pkg::cscba_state_t state_q, state_d;
  cscba_pkg::cscba_flags_t flags_q, flags_d;
  logic [7:0] acc_q, acc_d;
  logic [23:0] ptr_q, ptr_d;
  logic [23:0] cnt_q, cnt_d;
  logic mode_q, mode_d;
  logic wide_q, wide_d;
  logic scan_q, scan_d;
  logic inv_q, inv_d;
  logic [1:0] lead_q, lead_d;
  logic [7:0] data_q;
  logic [31:0] cyc_q, cyc_d;
  logic [31:0] rdata_q, rdata_d;
  logic mem_rd_q;
  logic busy_q;

  // ****************************************
  // register decode
  // ****************************************
  wire logic idle = (state_q == cscba_pkg::ST_IDLE);
  wire logic [7:0] cmd_op = i_wdata[cscba_pkg::CMD_OP_LSB +: 8];
  wire logic [7:0] cmd_pfx = i_wdata[cscba_pkg::CMD_PFX_LSB +: 8];
  wire logic pfx_ok = (cmd_pfx == cscba_pkg::PFX_NONE) || (cmd_pfx == cscba_pkg::PFX_SHORT)
                      || (cmd_pfx == cscba_pkg::PFX_LONG);
  wire logic pfx_given = (cmd_pfx != cscba_pkg::PFX_NONE);
  wire logic op_cmp = (cmd_op == cscba_pkg::OP_STEP) || (cmd_op == cscba_pkg::OP_SCAN);
  wire logic op_one = (cmd_op == cscba_pkg::OP_INVERT) || (cmd_op == cscba_pkg::OP_DECADJ);
  wire logic wr_cmd = i_wr && (i_addr == cscba_pkg::REG_CMD);
  wire logic start_cmp = wr_cmd && idle && pfx_ok && op_cmp;
  wire logic start_one = wr_cmd && idle && (cmd_pfx == cscba_pkg::PFX_NONE) && op_one;
  wire logic wr_reg = i_wr && idle;
  wire logic wr_acc = wr_reg && (i_addr == cscba_pkg::REG_ACC);
  wire logic wr_flags = wr_reg && (i_addr == cscba_pkg::REG_FLAGS);
  wire logic wr_ptr = wr_reg && (i_addr == cscba_pkg::REG_PTR);
  wire logic wr_cnt = wr_reg && (i_addr == cscba_pkg::REG_CNT);
  wire logic wr_mode = wr_reg && (i_addr == cscba_pkg::REG_MODE);

  wire logic start_wide = (cmd_pfx == cscba_pkg::PFX_LONG) ? 1'b1
                        : (cmd_pfx == cscba_pkg::PFX_SHORT) ? 1'b0 : mode_q;
  wire logic [1:0] start_lead = {1'b0, cmd_op == cscba_pkg::OP_SCAN} + {1'b0, pfx_given};

  // ****************************************
  // compare datapath
  // ****************************************
  // difference for flags only
  wire logic [7:0] diff = acc_q - data_q;
  wire logic half_borrow = (acc_q[3:0] < data_q[3:0]);
  wire logic equal = (acc_q == data_q);
  wire logic [23:0] ptr_inc = wide_q ? (ptr_q + cscba_pkg::ONE_24)
                                     : {ptr_q[23:16], ptr_q[15:0] + cscba_pkg::ONE_16};
  wire logic [23:0] cnt_dec = wide_q ? (cnt_q - cscba_pkg::ONE_24)
                                     : {cnt_q[23:16], cnt_q[15:0] - cscba_pkg::ONE_16};
  wire logic cnt_nz = wide_q ? (cnt_dec != cscba_pkg::CNT_RST)
                             : (cnt_dec[15:0] != cscba_pkg::CNT_RST[15:0]);
  // repeat while unequal and count left
  wire logic again = scan_q && !equal && cnt_nz;

  // ****************************************
  // decimal adjust datapath
  // ****************************************
  wire logic lo_big = (acc_q[3:0] > cscba_pkg::BCD_DIGIT_MAX);
  wire logic hi_big = (acc_q > cscba_pkg::BCD_BYTE_MAX);
  wire logic add_lo = flags_q.half || lo_big;
  wire logic add_hi = flags_q.carry || hi_big;
  wire logic [7:0] add_corr = (add_lo ? cscba_pkg::ADJ_LO : 8'h00) | (add_hi ? cscba_pkg::ADJ_HI : 8'h00);
  wire logic [7:0] sub_corr = (flags_q.half ? cscba_pkg::ADJ_LO : 8'h00)
                              | (flags_q.carry ? cscba_pkg::ADJ_HI : 8'h00);
  wire logic [7:0] adj_res = flags_q.sub ? (acc_q - sub_corr) : (acc_q + add_corr);
  // carry kept or set after add
  wire logic adj_carry = flags_q.sub ? flags_q.carry : add_hi;
  wire logic adj_half = flags_q.sub ? 1'b0 : lo_big;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    acc_d = acc_q;
    flags_d = flags_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    mode_d = mode_q;
    wide_d = wide_q;
    scan_d = scan_q;
    inv_d = inv_q;
    lead_d = lead_q;
    cyc_d = cyc_q + cscba_pkg::CYC_ONE;
    if (wr_acc)
    begin
      acc_d = i_wdata[7:0];
    end
    if (wr_flags)
    begin
      flags_d = i_wdata[7:0];
      flags_d.pad5 = 1'b0;
      flags_d.pad3 = 1'b0;
    end
    if (wr_ptr)
    begin
      ptr_d = i_wdata[23:0];
    end
    if (wr_cnt)
    begin
      cnt_d = i_wdata[23:0];
    end
    if (wr_mode)
    begin
      mode_d = i_wdata[cscba_pkg::MODE_WIDE_BIT];
    end
    case (state_q)
      cscba_pkg::ST_IDLE:
      begin
        cyc_d = cyc_q;
        if (start_cmp)
        begin
          // each busy state adds one, so count from zero
          cyc_d = 32'h00000000;
          wide_d = start_wide;
          scan_d = (cmd_op == cscba_pkg::OP_SCAN);
          lead_d = start_lead;
          state_d = (start_lead == cscba_pkg::LEAD_NONE) ? cscba_pkg::ST_ADDR : cscba_pkg::ST_LEAD;
        end
        else if (start_one)
        begin
          cyc_d = 32'h00000000;
          inv_d = (cmd_op == cscba_pkg::OP_INVERT);
          state_d = cscba_pkg::ST_ONE;
        end
      end
      cscba_pkg::ST_LEAD:
      begin
        lead_d = lead_q - cscba_pkg::LEAD_ONE;
        if (lead_q == cscba_pkg::LEAD_ONE)
        begin
          state_d = cscba_pkg::ST_ADDR;
        end
      end
      cscba_pkg::ST_ADDR:
      begin
        state_d = cscba_pkg::ST_WAIT;
      end
      cscba_pkg::ST_WAIT:
      begin
        state_d = cscba_pkg::ST_EXEC;
      end
      cscba_pkg::ST_EXEC:
      begin
        // accumulator kept, pointer and count step
        ptr_d = ptr_inc;
        cnt_d = cnt_dec;
        flags_d.sign = diff[7];
        flags_d.zero = equal;
        flags_d.half = half_borrow;
        flags_d.sub = 1'b1;
        flags_d.pv = cnt_nz;
        state_d = again ? cscba_pkg::ST_ADDR : cscba_pkg::ST_IDLE;
      end
      cscba_pkg::ST_ONE:
      begin
        if (inv_q)
        begin
          acc_d = ~acc_q;
          flags_d.half = 1'b1;
          flags_d.sub = 1'b1;
        end
        else
        begin
          acc_d = adj_res;
          flags_d.carry = adj_carry;
          flags_d.half = adj_half;
          flags_d.sign = adj_res[7];
          flags_d.zero = (adj_res == 8'h00);
          flags_d.pv = ~^adj_res;
        end
        state_d = cscba_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = cscba_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (!i_rd)
    begin
      rdata_d = 32'h00000000;
    end
    else if (i_addr == cscba_pkg::REG_ACC)
    begin
      rdata_d = {24'h000000, acc_q};
    end
    else if (i_addr == cscba_pkg::REG_FLAGS)
    begin
      rdata_d = {24'h000000, flags_q};
    end
    else if (i_addr == cscba_pkg::REG_PTR)
    begin
      rdata_d = {8'h00, ptr_q};
    end
    else if (i_addr == cscba_pkg::REG_CNT)
    begin
      rdata_d = {8'h00, cnt_q};
    end
    else if (i_addr == cscba_pkg::REG_MODE)
    begin
      rdata_d = {31'h00000000, mode_q};
    end
    else if (i_addr == cscba_pkg::REG_STATUS)
    begin
      rdata_d = {31'h00000000, busy_q};
    end
    else if (i_addr == cscba_pkg::REG_CYCLES)
    begin
      rdata_d = cyc_q;
    end
  end

  // ****************************************
  // flops
  // ****************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_q <= cscba_pkg::ST_IDLE;
      acc_q <= cscba_pkg::ACC_RST;
      flags_q <= cscba_pkg::FLAGS_RST;
      ptr_q <= cscba_pkg::PTR_RST;
      cnt_q <= cscba_pkg::CNT_RST;
      mode_q <= 1'b0;
      wide_q <= 1'b0;
      scan_q <= 1'b0;
      inv_q <= 1'b0;
      lead_q <= cscba_pkg::LEAD_NONE;
      data_q <= 8'h00;
      cyc_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      mem_rd_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      wide_q <= wide_d;
      scan_q <= scan_d;
      inv_q <= inv_d;
      lead_q <= lead_d;
      data_q <= (state_q == cscba_pkg::ST_WAIT) ? i_mem_data : data_q;
      cyc_q <= cyc_d;
      rdata_q <= rdata_d;
      mem_rd_q <= (state_d == cscba_pkg::ST_ADDR);
      busy_q <= (state_d != cscba_pkg::ST_IDLE);
    end
  end

  assign o_rdata = rdata_q;
  assign o_busy = busy_q;
  assign o_mem_rd = mem_rd_q;
  assign o_mem_addr = ptr_q;
  assign o_acc = acc_q;
  assign o_flags = flags_q;

endmodule : cscba_top

`default_nettype wire

// ### dv/cscba_mem.sv
// data memory model behind the datapath read port
// assumes one read request per cycle at most
`timescale 1ns/100ps
`default_nettype none
module cscba_mem (
  input wire logic i_clk,
  input wire logic i_rd,
  input wire logic [23:0] i_addr,
  output logic [7:0] o_data
);
  logic [7:0] mem [256];
  initial o_data = 8'h00;
  // byte valid one cycle after the request, then toggled garbage
  always @(posedge i_clk)
    o_data <= i_rd ? mem[i_addr[7:0]] : ~o_data;
endmodule : cscba_mem
`default_nettype wire

// ### dv/cscba_chk.sv
// port-level assertions for the datapath
// bound to cscba_top; one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module cscba_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_busy,
  input wire logic o_mem_rd,
  input wire logic [23:0] o_mem_addr,
  input wire logic [7:0] i_mem_data,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_flags
);
  wire cmd = i_wr && i_addr == cscba_pkg::REG_CMD && !o_busy;
  wire [15:0] cw = i_wdata[15:0];
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // ****************************************
  // assertions
  // ****************************************
  a_step_time: assert property (cmd && cw == 16'h00a1 |=> o_busy [*3] ##1 !o_busy)
    else $error("step length wrong");
  a_acc_kept: assert property (o_mem_rd |=> $stable(o_acc) [*3])
    else $error("accumulator changed by compare");
  a_ptr_up: assert property (o_mem_rd |-> ##3 o_mem_addr[15:0] == $past(o_mem_addr[15:0], 3) + 16'h0001)
    else $error("pointer not incremented");
  a_cmp_flags: assert property (o_mem_rd |-> ##3 o_flags[1] && o_flags[0] == $past(o_flags[0], 3))
    else $error("compare subtract or carry wrong");
  a_cmp_zero: assert property (o_mem_rd |=> ##2 o_flags[6] == ($past(o_acc, 2) == $past(i_mem_data, 2)))
    else $error("compare zero wrong");
  a_pass_gap: assert property (o_mem_rd |=> !o_mem_rd [*2])
    else $error("pass shorter than three cycles");
  a_invert_op: assert property (cmd && cw == 16'h002f |=>
    o_busy ##1 !o_busy && o_acc == ~$past(o_acc, 2) && o_flags[4] && o_flags[1] && o_flags[7:6] == $past(o_flags[7:6], 2))
    else $error("invert wrong");
  a_adjust_flags: assert property (cmd && cw == 16'h0027 |=>
    ##1 o_flags[2] == ~^o_acc && o_flags[7] == o_acc[7] && o_flags[1] == $past(o_flags[1], 2))
    else $error("adjust flags wrong");
endmodule : cscba_chk
bind cscba_top cscba_chk chk_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .o_busy(o_busy), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .i_mem_data(i_mem_data),
  .o_acc(o_acc), .o_flags(o_flags));
`default_nettype wire

// ### dv/cscba_tb_top.sv
// self-checking bench for cscba_top with a data memory model
// assumes the model answers a read one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module cscba_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic busy, mrd;
  logic [23:0] mad;
  logic [7:0] mdat, acc, flg;
  logic [7:0] pfx [3] = '{cscba_pkg::PFX_NONE, cscba_pkg::PFX_SHORT, cscba_pkg::PFX_LONG};
  int mismatches = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  cscba_top dut_u (.i_clk_sys(clk), .i_rst(rst), .i_addr(ad), .i_wdata(wd), .i_wr(we), .i_rd(re),
    .o_rdata(rdat), .o_busy(busy), .o_mem_rd(mrd), .o_mem_addr(mad), .i_mem_data(mdat), .o_acc(acc),
    .o_flags(flg));
  cscba_mem mem_u (.i_clk(clk), .i_rd(mrd), .i_addr(mad), .o_data(mdat));
  // ****************************************
  // bus tasks and expectations
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    ad <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    num_checks++;
    if (rdat !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, rdat);
    end
  endtask : rchk
  task automatic run(input logic [7:0] a, f, input logic [15:0] c);
    wreg(cscba_pkg::REG_ACC, {24'h0, a});
    wreg(cscba_pkg::REG_FLAGS, {24'h0, f});
    wreg(cscba_pkg::REG_CMD, {16'h0, c});
    for (int i = 0; i < 500; i++)
    begin
      @(posedge clk);
      #1;
      if (busy === 1'b0)
        return;
    end
    mismatches++;
    $display("[FAIL] busy expected 0 seen %b", busy);
    give_verdict();
  endtask : run
  task automatic cmp_case(input logic [7:0] op, pf, a, f, input logic [23:0] p, n, input logic m);
    logic w, z;
    logic [7:0] b, d;
    int k;
    w = pf == cscba_pkg::PFX_LONG || (pf == cscba_pkg::PFX_NONE && m);
    wreg(cscba_pkg::REG_PTR, {8'h00, p});
    wreg(cscba_pkg::REG_CNT, {8'h00, n});
    wreg(cscba_pkg::REG_MODE, {31'h0, m});
    run(a, f, {pf, op});
    k = 0;
    do
    begin
      b = mem_u.mem[p[7:0]];
      k++;
      p = w ? p + 24'h1 : {p[23:16], p[15:0] + 16'h1};
      n = w ? n - 24'h1 : {n[23:16], n[15:0] - 16'h1};
      z = w ? n == 24'h0 : n[15:0] == 16'h0;
    end
    while (op == cscba_pkg::OP_SCAN && b != a && !z);
    d = a - b;
    rchk("acc", cscba_pkg::REG_ACC, {24'h0, a});
    rchk("ptr", cscba_pkg::REG_PTR, {8'h00, p});
    rchk("cnt", cscba_pkg::REG_CNT, {8'h00, n});
    rchk("flags", cscba_pkg::REG_FLAGS, {24'h0, d[7], a == b, 1'b0, a[3:0] < b[3:0], 1'b0, !z, 1'b1, f[0]});
    rchk("cycles", cscba_pkg::REG_CYCLES, 32'(3 * k + (pf != 8'h00) + (op == cscba_pkg::OP_SCAN)));
  endtask : cmp_case
  task automatic acc_case(input logic [7:0] op, a, f);
    logic h, c;
    logic [7:0] r, g;
    run(a, f, {cscba_pkg::PFX_NONE, op});
    c = f[0] || (!f[1] && a > cscba_pkg::BCD_BYTE_MAX);
    h = !f[1] && a[3:0] > cscba_pkg::BCD_DIGIT_MAX;
    r = f[1] ? a - {f[0] ? 4'h6 : 4'h0, f[4] ? 4'h6 : 4'h0} : a + {c ? 4'h6 : 4'h0, f[4] || h ? 4'h6 : 4'h0};
    g = {r[7], r == 8'h00, 1'b0, h, 1'b0, ~^r, f[1], c};
    if (op == cscba_pkg::OP_INVERT)
    begin
      r = ~a;
      g = f & 8'hc5 | 8'h12;
    end
    rchk("acc", cscba_pkg::REG_ACC, {24'h0, r});
    rchk("flags", cscba_pkg::REG_FLAGS, {24'h0, g});
    rchk("cycles", cscba_pkg::REG_CYCLES, 32'h1);
  endtask : acc_case
  initial
  begin
    void'($urandom(32'hddbb9011));
    for (int i = 0; i < 256; i++)
      mem_u.mem[i] = 8'($urandom_range(15));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i <= 32; i += 4)
      rchk("reset", 8'(i), 32'h0);
    for (int i = 0; i < 24; i++)
      cmp_case(i < 12 ? cscba_pkg::OP_STEP : cscba_pkg::OP_SCAN, pfx[i % 3], 8'($urandom_range(15)), 8'($urandom),
        24'($urandom), i < 12 ? 24'(i % 3) : 24'($urandom_range(20, 1)), 1'($urandom));
    mem_u.mem[0] = 8'hee;
    cmp_case(cscba_pkg::OP_SCAN, pfx[0], 8'hee, 8'h01, 24'h12fffe, 24'h340000, 1'b0);
    cmp_case(cscba_pkg::OP_SCAN, pfx[0], 8'hee, 8'h00, 24'h00ffff, 24'h010000, 1'b1);
    cmp_case(cscba_pkg::OP_SCAN, pfx[1], 8'hee, 8'h00, 24'h00ffff, 24'h010000, 1'b1);
    for (int i = 0; i < 40; i++)
      acc_case(i < 6 ? cscba_pkg::OP_INVERT : cscba_pkg::OP_DECADJ, 8'($urandom), 8'($urandom));
    acc_case(cscba_pkg::OP_DECADJ, 8'h3c, 8'h00);
    give_verdict();
  end
endmodule : cscba_tb_top
`default_nettype wire
